// ---- design/sar_sync_aux_regs.sv ----
// Functional notes
// - No sync pulse reaches any sync function unless master sync enable is set.
// - Divider gets sync pulses only while divider and master sync enables are set.
// - Continuous mode: with next-sync-only clear, every sync pulse resyncs the divider.
// - Next-sync-only mode: divider aligns to first pulse, later pulses ignored.
// - Next-sync-only mode: divider sync enable clears itself after the divider syncs.
// - Output-enable-pin enable set: pin acts as output enable; clear: pin ignored.
// - Low-rate detect enabled and encode below about 5 MSPS starts internal oscillator.
// - Low-rate detect disabled: detector never starts the internal oscillator.
// - Force-run bit runs the internal oscillator whatever the detector says.
// - Pull-down disable bit switches off the serial data pin pull-down.
// - Reset values: sync control 0x01, aux control 0x88.
//
// Purpose: sync control and aux control registers with the logic they steer
// Assumes: register port driven by a serial port engine on the core clock
// Notes:   pins pass two flip-flops; all outputs are registered
`timescale 1ns/1ps
`include "sar_defines.svh"

module sar_sync_aux_regs (
  input  wire logic        CORE_CLK_IN,              // core clock, 100 MHz
  input  wire logic        RESET_IN,                 // synchronous reset, active high
  input  wire logic [12:0] REG_ADDR_IN,              // register address
  input  wire logic        REG_WR_IN,                // write strobe, one cycle
  input  wire logic        REG_RD_IN,                // read strobe, one cycle
  input  wire logic [7:0]  REG_WDATA_IN,             // write data
  output logic      [7:0]  REG_RDATA_OUT,            // read data
  output logic             REG_RVALID_OUT,           // read data valid pulse
  input  wire logic        SYNC_PIN_IN,              // external sync pin
  input  wire logic        OUTPUT_ENABLE_PIN_N_IN,   // output enable pin, active low
  input  wire logic        ENCODE_CLK_PIN_IN,        // encode clock pin
  output logic             DIV_SYNC_OUT,             // divider resync pulse
  output logic             DATA_OUT_EN_OUT,          // data outputs enabled
  output logic             OSC_RUN_OUT,              // internal oscillator run
  output logic             SDIO_PULLDOWN_EN_OUT      // serial data pin pull-down on
);

  // ****************************************************************
  // state
  // ****************************************************************
  sar_pkg::sar_state_t r_reg;
  sar_pkg::sar_state_t r_next;
  logic                low_rate;
  logic                sync_edge;
  logic                wr_sync;
  logic                wr_aux;

  function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
    masked = d & m;
  endfunction

  function automatic logic [7:0] reg_read(input logic [12:0] a,
                                          input sar_pkg::sar_sync_ctrl_t s,
                                          input sar_pkg::sar_aux_ctrl_t x);
    if (a == `SAR_SYNC_CTRL_ADDR) begin
      reg_read = masked(s, `SAR_SYNC_CTRL_WMASK);
    end else if (a == `SAR_AUX_CTRL_ADDR) begin
      reg_read = masked(x, `SAR_AUX_CTRL_WMASK);
    end else begin
      reg_read = `SAR_READ_ZERO;
    end
  endfunction

  // ****************************************************************
  // low encode rate detector
  // ****************************************************************
  sar_low_rate_det u_det (
    .clk_in       (CORE_CLK_IN),
    .rst_in       (RESET_IN),
    .enc_clk_in   (ENCODE_CLK_PIN_IN),
    .det_en_in    (r_reg.aux_ctrl.low_rate_det_en),
    .low_rate_out (low_rate)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  assign sync_edge = r_reg.sync_sync && !r_reg.sync_prev;
  assign wr_sync   = REG_WR_IN && (REG_ADDR_IN == `SAR_SYNC_CTRL_ADDR);
  assign wr_aux    = REG_WR_IN && (REG_ADDR_IN == `SAR_AUX_CTRL_ADDR);

  always_comb begin
    r_next           = r_reg;
    r_next.sync_meta = SYNC_PIN_IN;
    r_next.sync_sync = r_reg.sync_meta;
    r_next.sync_prev = r_reg.sync_sync;
    r_next.oe_meta   = OUTPUT_ENABLE_PIN_N_IN;
    r_next.oe_sync   = r_reg.oe_meta;

    r_next.div_sync  = sync_edge && r_reg.sync_ctrl.master_sync_en
                       && r_reg.sync_ctrl.div_sync_en;
    // one-shot: first forwarded pulse drops the divider enable
    if (r_next.div_sync && r_reg.sync_ctrl.next_sync_only) begin
      r_next.sync_ctrl.div_sync_en = 1'b0;
    end
    // a write landing with the self-clear wins, so software can re-arm
    if (wr_sync) begin
      r_next.sync_ctrl = masked(REG_WDATA_IN, `SAR_SYNC_CTRL_WMASK);
    end
    if (wr_aux) begin
      r_next.aux_ctrl = masked(REG_WDATA_IN, `SAR_AUX_CTRL_WMASK);
    end

    r_next.data_oe = r_reg.aux_ctrl.oe_pin_en ? !r_reg.oe_sync : 1'b1;
    r_next.osc_run = r_reg.aux_ctrl.osc_force_run
                     || (r_reg.aux_ctrl.low_rate_det_en && low_rate);
    r_next.pd_en   = !r_reg.aux_ctrl.pulldown_dis;

    r_next.rvalid = REG_RD_IN;
    r_next.rdata  = REG_RD_IN ? reg_read(REG_ADDR_IN, r_reg.sync_ctrl, r_reg.aux_ctrl)
                              : `SAR_READ_ZERO;
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      r_reg           <= '0;
      r_reg.sync_ctrl <= `SAR_SYNC_CTRL_RST;
      r_reg.aux_ctrl  <= `SAR_AUX_CTRL_RST;
      r_reg.data_oe   <= 1'b1;
      r_reg.pd_en     <= 1'b1;
      // oe synchroniser starts at the enabled level, else data_oe blips low after reset
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign REG_RDATA_OUT        = r_reg.rdata;
  assign REG_RVALID_OUT       = r_reg.rvalid;
  assign DIV_SYNC_OUT         = r_reg.div_sync;
  assign DATA_OUT_EN_OUT      = r_reg.data_oe;
  assign OSC_RUN_OUT          = r_reg.osc_run;
  assign SDIO_PULLDOWN_EN_OUT = r_reg.pd_en;

  // ****************************************************************
  // checks
  // ****************************************************************
  master_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    DIV_SYNC_OUT |-> $past(r_reg.sync_ctrl.master_sync_en))
    else $error("divider sync without master enable");

  div_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    !r_reg.sync_ctrl.div_sync_en |=> !DIV_SYNC_OUT)
    else $error("divider sync while divider enable clear");

  cont_fire_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    sync_edge && r_reg.sync_ctrl.master_sync_en && r_reg.sync_ctrl.div_sync_en
    |=> DIV_SYNC_OUT)
    else $error("enabled sync edge not forwarded");

  cont_keep_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    DIV_SYNC_OUT && !$past(r_reg.sync_ctrl.next_sync_only) && !$past(wr_sync)
    |-> r_reg.sync_ctrl.div_sync_en)
    else $error("continuous mode lost divider enable");

  oneshot_clr_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    DIV_SYNC_OUT && $past(r_reg.sync_ctrl.next_sync_only) && !$past(wr_sync)
    |-> !r_reg.sync_ctrl.div_sync_en)
    else $error("one-shot did not clear divider enable");

  oneshot_once_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    DIV_SYNC_OUT && $past(r_reg.sync_ctrl.next_sync_only) && !$past(wr_sync)
    ##0 !wr_sync[*3] |=> !DIV_SYNC_OUT)
    else $error("one-shot forwarded a later pulse");

  sync_edge_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    DIV_SYNC_OUT |-> $past(SYNC_PIN_IN, 3) && !$past(SYNC_PIN_IN, 4))
    else $error("divider sync not tied to a pin rising edge");

  oe_pin_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    r_reg.aux_ctrl.oe_pin_en |=> DATA_OUT_EN_OUT == !$past(r_reg.oe_sync))
    else $error("output enable pin not obeyed");

  oe_ignore_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    !r_reg.aux_ctrl.oe_pin_en |=> DATA_OUT_EN_OUT)
    else $error("output enable pin not ignored");

  osc_detect_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    r_reg.aux_ctrl.low_rate_det_en && low_rate |=> OSC_RUN_OUT)
    else $error("low rate did not start oscillator");

  osc_idle_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    !r_reg.aux_ctrl.low_rate_det_en && !r_reg.aux_ctrl.osc_force_run |=> !OSC_RUN_OUT)
    else $error("oscillator ran with detector off");

  osc_force_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    r_reg.aux_ctrl.osc_force_run |=> OSC_RUN_OUT)
    else $error("force-run did not run oscillator");

  pulldown_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    r_reg.aux_ctrl.pulldown_dis |=> !SDIO_PULLDOWN_EN_OUT)
    else $error("pull-down not switched off");

  reset_val_a: assert property (@(posedge CORE_CLK_IN)
    $past(RESET_IN) && RESET_IN == 1'b0 |-> r_reg.sync_ctrl == `SAR_SYNC_CTRL_RST
    && r_reg.aux_ctrl == `SAR_AUX_CTRL_RST)
    else $error("reset values wrong");

  reset_out_a: assert property (@(posedge CORE_CLK_IN)
    $past(RESET_IN) && RESET_IN == 1'b0 |-> DATA_OUT_EN_OUT && SDIO_PULLDOWN_EN_OUT
    && !OSC_RUN_OUT && !DIV_SYNC_OUT && !REG_RVALID_OUT)
    else $error("outputs wrong after reset");

  // hardware only ever clears the divider enable; re-arming is up to software
  div_rearm_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    !r_reg.sync_ctrl.div_sync_en && !wr_sync |=> !r_reg.sync_ctrl.div_sync_en)
    else $error("divider enable re-armed without a write");

  div_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    DIV_SYNC_OUT |=> !DIV_SYNC_OUT)
    else $error("divider sync longer than one cycle");

  pulldown_on_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    !r_reg.aux_ctrl.pulldown_dis |=> SDIO_PULLDOWN_EN_OUT)
    else $error("pull-down off while enabled");

  read_valid_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    REG_RD_IN |=> REG_RVALID_OUT)
    else $error("read not answered in one cycle");

  read_idle_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
    !REG_RD_IN |=> !REG_RVALID_OUT && REG_RDATA_OUT == `SAR_READ_ZERO)
    else $error("read data shown without a read");

endmodule

// ---- design/sar_defines.svh ----
// Purpose: offsets, reset values, field masks and timing counts of the sync/aux register bank
// Assumes: core clock of 100 MHz
// Notes:   definitions only
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define SAR_ADDR_W          13
`define SAR_SYNC_CTRL_ADDR  13'h0100
`define SAR_AUX_CTRL_ADDR   13'h0101
`define SAR_SYNC_CTRL_RST   8'h01
`define SAR_AUX_CTRL_RST    8'h88
`define SAR_SYNC_CTRL_WMASK 8'h07
`define SAR_AUX_CTRL_WMASK  8'h8D
`define SAR_READ_ZERO       8'h00

// ****************************************************************
// timing
// ****************************************************************
`define SAR_CLK_PERIOD_NS   10
// encode period above this means an encode rate below 5 MSPS
`define SAR_LOW_RATE_NS     200
`define SAR_LOW_RATE_CYC    ((`SAR_LOW_RATE_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_CNT_W           8

`endif

// ---- design/sar_pkg.sv ----
// Purpose: types of the sync/aux register bank
// Assumes: field layout matches the masks in sar_defines.svh
// Notes:   the two register structs are 8 bits each, msb first
package sar_pkg;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       next_sync_only;
    logic       div_sync_en;
    logic       master_sync_en;
  } sar_sync_ctrl_t;

  typedef struct packed {
    logic       oe_pin_en;
    logic [2:0] rsvd_hi;
    logic       low_rate_det_en;
    logic       osc_force_run;
    logic       rsvd_lo;
    logic       pulldown_dis;
  } sar_aux_ctrl_t;

  typedef struct packed {
    sar_sync_ctrl_t sync_ctrl;
    sar_aux_ctrl_t  aux_ctrl;
    logic           sync_meta;
    logic           sync_sync;
    logic           sync_prev;
    logic           oe_meta;
    logic           oe_sync;
    logic           div_sync;
    logic           data_oe;
    logic           osc_run;
    logic           pd_en;
    logic [7:0]     rdata;
    logic           rvalid;
  } sar_state_t;

  typedef struct packed {
    logic       enc_meta;
    logic       enc_sync;
    logic       enc_prev;
    logic [7:0] cnt;
    logic       low_rate;
  } sar_det_state_t;

endpackage

// ---- design/sar_low_rate_det.sv ----
// Purpose: flags an encode clock slower than the low-rate threshold
// Assumes: encode clock pin is asynchronous to the core clock
// Notes:   a stopped encode clock also reads as low rate
`timescale 1ns/1ps
`include "sar_defines.svh"

module sar_low_rate_det (
  input  wire logic clk_in,        // core clock
  input  wire logic rst_in,        // synchronous reset, active high
  input  wire logic enc_clk_in,    // encode clock pin
  input  wire logic det_en_in,     // detector enable
  output logic      low_rate_out   // encode rate below threshold
);

  localparam logic [7:0] THRESH = 8'(`SAR_LOW_RATE_CYC);

  sar_pkg::sar_det_state_t r_reg;
  sar_pkg::sar_det_state_t r_next;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  always_comb begin
    r_next          = r_reg;
    r_next.enc_meta = enc_clk_in;
    r_next.enc_sync = r_reg.enc_meta;
    r_next.enc_prev = r_reg.enc_sync;
    if (!det_en_in) begin
      r_next.cnt      = 8'h00;
      r_next.low_rate = 1'b0;
    end else if (r_reg.enc_sync && !r_reg.enc_prev) begin
      // judge the whole period just ended
      r_next.cnt      = 8'h00;
      r_next.low_rate = (sat_inc(r_reg.cnt) > THRESH);
    end else begin
      r_next.cnt = sat_inc(r_reg.cnt);
      if (sat_inc(r_reg.cnt) > THRESH) begin
        r_next.low_rate = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign low_rate_out = r_reg.low_rate;

  det_slow_a: assert property (@(posedge clk_in) disable iff (rst_in)
    det_en_in && r_reg.cnt > THRESH && !(r_reg.enc_sync && !r_reg.enc_prev) |=> low_rate_out)
    else $error("slow encode clock not flagged");

  det_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !det_en_in |=> !low_rate_out)
    else $error("disabled detector flagged low rate");

endmodule

// ---- sim/sar_far_model.sv ----
// Purpose: far-side pins: sync pulse source and encode clock
// Assumes: sync pulses launched on the core clock rising edge
// Notes:   encode clock runs on its own time base, unrelated in phase
`timescale 1ns/1ps

module sar_far_model (
  input  wire logic       clk_in,          // core clock
  input  wire logic [7:0] enc_half_ns_in,  // encode half period in ns, 0 stops it
  output logic            sync_pin_out,    // sync pin
  output logic            enc_clk_out      // encode clock pin
);
  // ****************************************************************
  // pin drivers
  // ****************************************************************
  initial sync_pin_out = 1'b0;
  initial enc_clk_out = 1'b0;

  always begin
    // an unknown half period at time zero falls to the stopped branch, never a zero delay
    if (enc_half_ns_in > 8'h00) #(enc_half_ns_in) enc_clk_out = ~enc_clk_out;
    else #7;
  end

  // three samples low and high each, so no edge can slip between flops
  task automatic pulse();
    @(posedge clk_in);
    sync_pin_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    sync_pin_out <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
endmodule

// ---- sim/sar_sync_aux_regs_tb_top.sv ----
// Purpose: self-checking bench of the sync/aux register bank
// Assumes: register port, sync pin and output enable pin driven on the core clock rising edge
// Notes:   random reserved bits ride along every sync control mode write
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end

module sar_sync_aux_regs_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [12:0] addr = 13'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic        oe_pin_n = 1'b0;
  logic [7:0]  enc_half = 8'h00;
  logic [7:0]  rdata;
  logic        rvalid, div_sync, data_en, osc_run, pd_en, sync_pin, enc_clk;
  int          n_fail = 0, tests_run = 0, n_div = 0, base, i, seed = 51112;
  logic [31:0] r;
  logic [7:0]  c;
  logic [7:0]  osc_aux [5] = '{8'h08, 8'h08, 8'h08, 8'h00, 8'h04};
  logic [7:0]  osc_half [5] = '{8'h00, 8'h96, 8'h14, 8'h00, 8'h3C};
  logic        osc_exp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  always #5 clk = ~clk;
  always @(posedge clk) if (div_sync === 1'b1) n_div <= n_div + 1;

  sar_sync_aux_regs dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .SYNC_PIN_IN(sync_pin), .OUTPUT_ENABLE_PIN_N_IN(oe_pin_n),
    .ENCODE_CLK_PIN_IN(enc_clk), .DIV_SYNC_OUT(div_sync), .DATA_OUT_EN_OUT(data_en),
    .OSC_RUN_OUT(osc_run), .SDIO_PULLDOWN_EN_OUT(pd_en));

  sar_far_model u_far (.clk_in(clk), .enc_half_ns_in(enc_half), .sync_pin_out(sync_pin),
    .enc_clk_out(enc_clk));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic int exp_pulses(input logic [7:0] m, input int n);
    return (m[0] & m[1]) ? (m[2] ? 1 : n) : 0;
  endfunction

  // one-shot drops the divider enable once it has fired
  function automatic logic [7:0] exp_sync(input logic [7:0] m);
    return (m & 8'h07) & ((m[0] & m[1] & m[2]) ? 8'hFD : 8'hFF);
  endfunction

  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
    int k;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    for (k = 0; k < 3 && rvalid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 3) begin
      n_fail++;
      close_out();
    end
    `CHK(rdata, e)
  endtask

  initial begin
    #900000;
    n_fail++;
    close_out();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({data_en, osc_run, pd_en}, 3'h5)
    rd_chk(13'h0100, 8'h01);
    rd_chk(13'h0101, 8'h88);
    wr_reg(13'h1100, 8'h06);
    rd_chk(13'h0100, 8'h01);
    rd_chk(13'h0102, 8'h00);
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      wr_reg(13'h0100, r[7:0]);
      wr_reg(13'h0101, r[15:8]);
      rd_chk(13'h0100, r[7:0] & 8'h07);
      rd_chk(13'h0101, r[15:8] & 8'h8D);
    end
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      c = {r[7:3], i[2:0]};
      wr_reg(13'h0100, c);
      base = n_div;
      u_far.pulse();
      u_far.pulse();
      repeat (4) @(posedge clk);
      `CHK(n_div - base, exp_pulses(c, 2))
      rd_chk(13'h0100, exp_sync(c));
    end
    wr_reg(13'h0101, 8'h80);
    @(posedge clk) oe_pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    `CHK(data_en, 1'b0)
    wr_reg(13'h0101, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    `CHK(data_en, 1'b1)
    @(posedge clk) oe_pin_n <= 1'b0;
    for (i = 0; i < 5; i++) begin
      wr_reg(13'h0101, osc_aux[i]);
      @(posedge clk) enc_half <= osc_half[i];
      repeat (60) @(posedge clk);
      #1;
      `CHK(osc_run, osc_exp[i])
    end
    wr_reg(13'h0101, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    `CHK(pd_en, 1'b0)
    wr_reg(13'h0101, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK(pd_en, 1'b1)
    close_out();
  end
endmodule
